// [design/bsc_boot_strap_clock_select.sv]
// Overview of operation
// - Boot source strap latched at reset release decides code source.
// - Strap high: wait for host download over chosen host interface.
// - Strap low: autoboot, generate addresses, read bytes on memory pins (serial host modes only).
// - Once running, boot pin becomes open-drain active-low message request.
// - Parallel host modes give all twelve pins to the parallel interface.
// - Serial host modes use the pins for external memory unless general-purpose use is enabled.
// - Serial modes allow general-purpose pin use when application supports it.
// - Pins stay high-impedance inputs until a mode assigns a role.
// - Pin levels sampled at reset release fix the host mode.
// - Bypass strap low selects PLL clock, high selects reference input.
// - Software-driven mux picks PLL reference from three sources.
// - PLL derives core clocks and audio master timing.
// - Clock manager holds a 33-bit sync time counter.
// - Bypass path runs slower; some features flagged unavailable.
// - Read, write and select straps decode into one of four host modes.
`timescale 1ns/1ps
`default_nettype none
module bsc_boot_strap_clock_select #(
  parameter int PIN_COUNT = bsc_pkg::MP_PIN_COUNT,
  parameter int ADDR_W = bsc_pkg::BOOT_ADDR_W,
  parameter int TB_WIDTH = bsc_pkg::SYNC_TIMEBASE_W,
  parameter int TB_DIV = bsc_pkg::TIMEBASE_DIV
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  // Strap and pin inputs
  input wire logic boot_source_strap_i,
  input wire logic read_strobe_i,
  input wire logic write_strobe_i,
  input wire logic pll_bypass_select_i,
  input wire logic [PIN_COUNT-1:0] mp_pins_i,
  // Boot sequencing
  input wire logic [ADDR_W-1:0] boot_length_i,
  input wire logic host_load_done_i,
  // Application side
  input wire logic app_general_pins_i,
  input wire logic [PIN_COUNT-1:0] app_pins_out_i,
  input wire logic [PIN_COUNT-1:0] app_pins_oe_i,
  input wire logic msg_pending_i,
  input wire logic [1:0] ref_select_i,
  input wire logic pll_clock_i,
  input wire logic bit_clock_one_i,
  input wire logic bit_clock_two_i,
  input wire logic ref_clock_input_i,
  input wire logic [PIN_COUNT-1:0] par_pins_out_i,
  input wire logic [PIN_COUNT-1:0] par_pins_oe_i,
  input wire logic timebase_clear_i,
  // Outputs
  output logic [PIN_COUNT-1:0] mp_pins_o,
  output logic [PIN_COUNT-1:0] mp_pins_oe_o,
  output logic boot_pin_o,
  output logic boot_pin_oe_o,
  output logic [2:0] host_mode_o,
  output logic [1:0] pin_role_o,
  output logic waiting_host_o,
  output logic autoboot_busy_o,
  output logic [ADDR_W-1:0] boot_addr_o,
  output logic boot_rd_o,
  output logic [bsc_pkg::EMEM_DATA_W-1:0] boot_byte_o,
  output logic boot_byte_valid_o,
  output logic app_running_o,
  output logic pll_bypassed_o,
  output logic reduced_features_o,
  output logic [1:0] pll_ref_sel_o,
  output logic pll_ref_clock_o,
  output logic dsp_clock_o,
  output logic audio_timing_tick_o,
  output logic [TB_WIDTH-1:0] av_sync_timebase_o
);

  initial
  begin
    if (PIN_COUNT <= bsc_pkg::EMEM_DATA_W || TB_DIV < 1 || ADDR_W < 1 ||
        ADDR_W < PIN_COUNT - bsc_pkg::EMEM_DATA_W)
      $error("bsc: unsupported parameter values");
  end

  typedef enum logic [1:0] {
    BSC_ST_STRAP,
    BSC_ST_HOST_WAIT,
    BSC_ST_AUTOBOOT,
    BSC_ST_RUN
  } bsc_boot_state_type;

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [4:0] strap_meta_q;
  logic [4:0] strap_sync_q;
  logic [PIN_COUNT-1:0] pins_meta_q;
  logic [PIN_COUNT-1:0] pins_sync_q;

  // Release after two edges so straps have settled
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Two-stage sync for pin levels
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_meta_q <= 5'h00;
      strap_sync_q <= 5'h00;
      pins_meta_q <= '0;
      pins_sync_q <= '0;
    end
    else
    begin
      strap_meta_q <= {boot_source_strap_i, read_strobe_i, write_strobe_i,
                       mp_pins_i[0], pll_bypass_select_i};
      strap_sync_q <= strap_meta_q;
      pins_meta_q <= mp_pins_i;
      pins_sync_q <= pins_meta_q;
    end
  end

  // ****************************************
  // Strap capture
  // ****************************************
  bsc_pkg::bsc_strap_type straps_q;
  logic [1:0] capture_cnt_q;
  logic captured_q;
  bsc_pkg::bsc_host_mode_type mode_q;

  // Wait for sync pipe to fill, then capture once
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      capture_cnt_q <= 2'h0;
    else if (!captured_q)
      capture_cnt_q <= capture_cnt_q + 2'h1;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      straps_q <= '0;
      captured_q <= 1'b0;
    end
    else if (!captured_q && capture_cnt_q == 2'h2)
    begin
      straps_q <= strap_sync_q;
      captured_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= bsc_pkg::BSC_HOST_NONE;
    else if (captured_q && mode_q == bsc_pkg::BSC_HOST_NONE)
    begin
      unique case ({straps_q.read_strobe, straps_q.write_strobe})
        2'b01: mode_q <= bsc_pkg::BSC_HOST_I2C;
        2'b10: mode_q <= bsc_pkg::BSC_HOST_SPI;
        2'b11: mode_q <= straps_q.parallel_select ? bsc_pkg::BSC_HOST_PAR_A
                                                  : bsc_pkg::BSC_HOST_PAR_B;
        default: mode_q <= bsc_pkg::BSC_HOST_I2C;
      endcase
    end
  end

  logic is_parallel;
  logic mode_known;
  assign is_parallel = (mode_q == bsc_pkg::BSC_HOST_PAR_A) || (mode_q == bsc_pkg::BSC_HOST_PAR_B);
  assign mode_known = (mode_q != bsc_pkg::BSC_HOST_NONE);

  // ****************************************
  // Boot sequencer
  // ****************************************
  bsc_boot_state_type state_q;
  logic [ADDR_W-1:0] addr_q;
  logic rd_q;
  logic fetch_done_q;
  logic byte_due_q;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= BSC_ST_STRAP;
      addr_q <= bsc_pkg::BOOT_ADDR_RESET;
      rd_q <= 1'b0;
      fetch_done_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        BSC_ST_STRAP:
          if (mode_known)
            state_q <= straps_q.boot_source_strap ? BSC_ST_HOST_WAIT : BSC_ST_AUTOBOOT;
        BSC_ST_HOST_WAIT:
          if (host_load_done_i)
            state_q <= BSC_ST_RUN;
        BSC_ST_AUTOBOOT:
          // Last byte is still in the pin pipe, so run only once it is taken
          if (fetch_done_q)
          begin
            if (boot_byte_valid_o && !boot_rd_o)
              state_q <= BSC_ST_RUN;
          end
          // Parallel modes own the pins, so autoboot cannot read memory there
          else if (!rd_q)
            rd_q <= !is_parallel;
          else
          begin
            rd_q <= 1'b0;
            if (addr_q == boot_length_i - ADDR_W'(1))
              fetch_done_q <= 1'b1;
            else
              addr_q <= addr_q + ADDR_W'(1);
          end
        BSC_ST_RUN: state_q <= BSC_ST_RUN;
      endcase
    end
  end

  // Byte taken two cycles after the strobe, once the pin sync shows it
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_addr_o <= '0;
      boot_rd_o <= 1'b0;
      byte_due_q <= 1'b0;
      boot_byte_o <= '0;
      boot_byte_valid_o <= 1'b0;
    end
    else
    begin
      boot_addr_o <= addr_q;
      boot_rd_o <= rd_q;
      byte_due_q <= boot_rd_o;
      boot_byte_valid_o <= byte_due_q;
      if (byte_due_q)
        boot_byte_o <= pins_sync_q[bsc_pkg::EMEM_DATA_W-1:0];
    end
  end

  // ****************************************
  // Pin roles
  // ****************************************
  bsc_pkg::bsc_pin_role_type role_d;
  bsc_pkg::bsc_pin_drive_type drive_d;

  always_comb
  begin
    role_d = bsc_pkg::BSC_PINS_IDLE;
    drive_d = '0;
    if (mode_known && is_parallel)
    begin
      role_d = bsc_pkg::BSC_PINS_PARALLEL;
      drive_d.out = par_pins_out_i;
      drive_d.oe = par_pins_oe_i;
    end
    else if (state_q == BSC_ST_AUTOBOOT && mode_known)
    begin
      role_d = bsc_pkg::BSC_PINS_EXT_MEM;
      // Address low bits on the upper pins, byte lines left as inputs
      drive_d.out = {addr_q[PIN_COUNT-bsc_pkg::EMEM_DATA_W-1:0], {bsc_pkg::EMEM_DATA_W{1'b0}}};
      drive_d.oe = {{(PIN_COUNT-bsc_pkg::EMEM_DATA_W){1'b1}}, {bsc_pkg::EMEM_DATA_W{1'b0}}};
    end
    else if (state_q == BSC_ST_RUN && app_general_pins_i)
    begin
      role_d = bsc_pkg::BSC_PINS_GENERAL;
      drive_d.out = app_pins_out_i;
      drive_d.oe = app_pins_oe_i;
    end
    else if (state_q == BSC_ST_RUN)
      role_d = bsc_pkg::BSC_PINS_EXT_MEM;
  end

  // Registered pin and status outputs
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mp_pins_o <= '0;
      mp_pins_oe_o <= '0;
      pin_role_o <= 2'h0;
      host_mode_o <= 3'h0;
      waiting_host_o <= 1'b0;
      autoboot_busy_o <= 1'b0;
      app_running_o <= 1'b0;
    end
    else
    begin
      mp_pins_o <= drive_d.out;
      mp_pins_oe_o <= drive_d.oe;
      pin_role_o <= role_d;
      host_mode_o <= mode_q;
      waiting_host_o <= state_q == BSC_ST_HOST_WAIT;
      autoboot_busy_o <= state_q == BSC_ST_AUTOBOOT;
      app_running_o <= state_q == BSC_ST_RUN;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_pin_o <= 1'b0;
      boot_pin_oe_o <= 1'b0;
    end
    else
    begin
      boot_pin_o <= 1'b0;
      boot_pin_oe_o <= state_q == BSC_ST_RUN && msg_pending_i;
    end
  end

  // ****************************************
  // Clock manager
  // ****************************************
  // Clock muxes are behavioural; a real part uses glitch-free cells
  // core clock select, reduced-feature flag
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_bypassed_o <= 1'b0;
      reduced_features_o <= 1'b0;
      pll_ref_sel_o <= bsc_pkg::REF_SEL_REF_CLOCK;
      pll_ref_clock_o <= 1'b0;
      dsp_clock_o <= 1'b0;
    end
    else
    begin
      pll_bypassed_o <= straps_q.pll_bypass_select;
      reduced_features_o <= straps_q.pll_bypass_select;
      pll_ref_sel_o <= ref_select_i;
      dsp_clock_o <= straps_q.pll_bypass_select ? ref_clock_input_i : pll_clock_i;
      unique case (ref_select_i)
        bsc_pkg::REF_SEL_BIT_CLOCK_ONE: pll_ref_clock_o <= bit_clock_one_i;
        bsc_pkg::REF_SEL_BIT_CLOCK_TWO: pll_ref_clock_o <= bit_clock_two_i;
        default: pll_ref_clock_o <= ref_clock_input_i;
      endcase
    end
  end

  logic [$clog2(TB_DIV+1)-1:0] div_q;
  logic tick_q;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else if (div_q == ($clog2(TB_DIV+1))'(TB_DIV - 1))
    begin
      div_q <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      audio_timing_tick_o <= 1'b0;
    else
      audio_timing_tick_o <= tick_q;
  end

  bsc_timebase #(
    .WIDTH(TB_WIDTH)
  ) u_timebase (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .tick_i(tick_q),
    .clear_i(timebase_clear_i),
    .count_o(av_sync_timebase_o)
  );

endmodule : bsc_boot_strap_clock_select
`default_nettype wire

// [common/bsc_pkg.sv]
package bsc_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int MP_PIN_COUNT = 12;
  localparam int EMEM_DATA_W = 8;
  localparam int BOOT_ADDR_W = 16;
  localparam int SYNC_TIMEBASE_W = 33;
  localparam int TIMEBASE_DIV = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [BOOT_ADDR_W-1:0] BOOT_ADDR_RESET = 16'h0000;
  localparam logic [SYNC_TIMEBASE_W-1:0] TIMEBASE_RESET = 33'h000000000;

  // ****************************************
  // PLL reference select encoding
  // ****************************************
  localparam logic [1:0] REF_SEL_REF_CLOCK = 2'h0;
  localparam logic [1:0] REF_SEL_BIT_CLOCK_ONE = 2'h1;
  localparam logic [1:0] REF_SEL_BIT_CLOCK_TWO = 2'h2;

  typedef enum logic [2:0] {
    BSC_HOST_NONE,
    BSC_HOST_I2C,
    BSC_HOST_SPI,
    BSC_HOST_PAR_A,
    BSC_HOST_PAR_B
  } bsc_host_mode_type;

  typedef enum logic [1:0] {
    BSC_PINS_IDLE,
    BSC_PINS_PARALLEL,
    BSC_PINS_EXT_MEM,
    BSC_PINS_GENERAL
  } bsc_pin_role_type;

  // Straps captured together at reset release
  typedef struct packed {
    logic boot_source_strap;
    logic read_strobe;
    logic write_strobe;
    logic parallel_select;
    logic pll_bypass_select;
  } bsc_strap_type;

  // Pin pair (out, oe) for the multi-purpose pins
  typedef struct packed {
    logic [MP_PIN_COUNT-1:0] out;
    logic [MP_PIN_COUNT-1:0] oe;
  } bsc_pin_drive_type;

endpackage : bsc_pkg

// [design/bsc_timebase.sv]
`timescale 1ns/1ps
`default_nettype none
module bsc_timebase #(
  parameter int WIDTH = bsc_pkg::SYNC_TIMEBASE_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic clear_i,
  output logic [WIDTH-1:0] count_o
);

  // ****************************************
  // Free-running sync counter
  // ****************************************
  // counter advance and clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_o <= '0;
    else if (clear_i)
      count_o <= '0;
    else if (tick_i)
      count_o <= count_o + WIDTH'(1);
  end

endmodule : bsc_timebase
`default_nettype wire

// [testbench/bsc_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module bsc_asserts #(
  parameter int PIN_COUNT = 12,
  parameter int ADDR_W = 16,
  parameter int TB_WIDTH = 33
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic read_strobe_i,
  input wire logic write_strobe_i,
  input wire logic [PIN_COUNT-1:0] mp_pins_i,
  input wire logic msg_pending_i,
  input wire logic pll_clock_i,
  input wire logic ref_clock_input_i,
  input wire logic [PIN_COUNT-1:0] mp_pins_oe_o,
  input wire logic boot_pin_o,
  input wire logic boot_pin_oe_o,
  input wire logic [2:0] host_mode_o,
  input wire logic [1:0] pin_role_o,
  input wire logic waiting_host_o,
  input wire logic [ADDR_W-1:0] boot_addr_o,
  input wire logic boot_rd_o,
  input wire logic boot_byte_valid_o,
  input wire logic app_running_o,
  input wire logic pll_bypassed_o,
  input wire logic dsp_clock_o,
  input wire logic audio_timing_tick_o,
  input wire logic [TB_WIDTH-1:0] av_sync_timebase_o
);
  logic [2:0] rel_q;
  logic rdy;
  // Settle count, skips the internal reset sync
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rel_q <= 3'h0;
    else if (rel_q != 3'h7)
      rel_q <= rel_q + 3'h1;
  end
  assign rdy = (rel_q == 3'h7);
  // Host mode from read, write and select levels
  function automatic logic [2:0] dec(input logic r, input logic w, input logic s);
    return (r && w) ? (s ? 3'h3 : 3'h4) : (r ? 3'h2 : 3'h1);
  endfunction : dec
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ****
  // Autoboot fetch steps
  // ****
  // Strobe, a quiet cycle, then the byte taken through the pin sync
  sequence s_fetch;
    !boot_rd_o ##1 (boot_byte_valid_o && !waiting_host_o);
  endsequence
  sequence s_pair;
    boot_rd_o ##2 boot_rd_o;
  endsequence
  a_mode_decode: assert property (host_mode_o != 3'h0 && $past(host_mode_o) == 3'h0
    |-> host_mode_o == dec(read_strobe_i, write_strobe_i, mp_pins_i[0])) else $error("bad mode");
  a_mode_hold: assert property (rdy && $past(host_mode_o) != 3'h0
    |-> $stable(host_mode_o)) else $error("mode moved");
  a_par_role: assert property (host_mode_o == 3'h3 || host_mode_o == 3'h4
    |-> ##3 pin_role_o == 2'h1) else $error("no parallel role");
  a_idle_hiz: assert property (pin_role_o == 2'h0 && $past(pin_role_o) == 2'h0
    |-> mp_pins_oe_o == '0) else $error("idle pins driven");
  a_fetch_step: assert property (boot_rd_o |=> s_fetch) else $error("bad fetch");
  a_addr_step: assert property (s_pair
    |-> boot_addr_o == $past(boot_addr_o, 2) + 1'b1) else $error("bad address");
  a_req_follow: assert property (app_running_o && $past(app_running_o)
    |-> boot_pin_oe_o == $past(msg_pending_i) && !boot_pin_o) else $error("bad request");
  a_dsp_clock: assert property (rdy && $stable(pll_bypassed_o)
    |-> dsp_clock_o == (pll_bypassed_o ? $past(ref_clock_input_i) : $past(pll_clock_i)))
    else $error("bad core clock");
  a_tick_rate: assert property (audio_timing_tick_o
    |=> !audio_timing_tick_o [*3] ##1 audio_timing_tick_o) else $error("bad tick");
  a_time_step: assert property (rdy && !$stable(av_sync_timebase_o)
    |-> av_sync_timebase_o == $past(av_sync_timebase_o) + 1'b1) else $error("bad count");
endmodule : bsc_asserts
bind bsc_boot_strap_clock_select bsc_asserts #(.PIN_COUNT(PIN_COUNT), .ADDR_W(ADDR_W),
  .TB_WIDTH(TB_WIDTH)) bsc_asserts_i (.clk_i, .nrst_i, .read_strobe_i, .write_strobe_i,
  .mp_pins_i, .msg_pending_i, .pll_clock_i, .ref_clock_input_i, .mp_pins_oe_o, .boot_pin_o,
  .boot_pin_oe_o, .host_mode_o, .pin_role_o, .waiting_host_o, .boot_addr_o, .boot_rd_o,
  .boot_byte_valid_o, .app_running_o, .pll_bypassed_o, .dsp_clock_o, .audio_timing_tick_o,
  .av_sync_timebase_o);
`default_nettype wire

// [testbench/bsc_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bsc_far_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] boot_addr_i,
  input wire logic waiting_host_i,
  input wire logic [7:0] host_delay_i,
  output logic [7:0] mem_byte_o,
  output logic load_done_o
);
  logic [7:0] wait_q;
  // Memory answers each address, held while it stands
  assign mem_byte_o = boot_addr_i[7:0] ^ 8'h5a;
  // Host ends its download after a set delay
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wait_q <= 8'h0;
      load_done_o <= 1'b0;
    end
    else
    begin
      wait_q <= waiting_host_i ? wait_q + 8'h1 : 8'h0;
      load_done_o <= waiting_host_i && (wait_q == host_delay_i);
    end
  end
endmodule : bsc_far_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic boot_s = 1'b0, rd_s = 1'b0, wr_s = 1'b0, sel_s = 1'b0, byp_s = 1'b0;
  logic app_gen = 1'b0, msg = 1'b0, ld;
  logic [1:0] ref_sel = 2'h0;
  logic [7:0] hdly = 8'h0, cyc = 8'h0, mem_b;
  logic [11:0] par_oe = 12'h0, pins, mp_pins_o, mp_pins_oe_o;
  logic [15:0] nxt = 16'h0, nbx = 16'h0, boot_addr_o;
  logic [7:0] boot_byte_o;
  logic [2:0] host_mode_o;
  logic [1:0] pin_role_o, pll_ref_sel_o;
  logic boot_pin_o, boot_pin_oe_o, waiting_host_o, autoboot_busy_o, boot_rd_o;
  logic boot_byte_valid_o, app_running_o, pll_bypassed_o, reduced_features_o;
  logic pll_ref_clock_o, dsp_clock_o, audio_timing_tick_o;
  logic [32:0] av_sync_timebase_o;
  int error_cnt = 0, total_checks = 0, rd_cnt = 0;
  logic [7:0] cyc_q = 8'h0;
  logic [1:0] ref_q = 2'h0;
  logic ref_exp;
  logic [32:0] tb0;
  // Reference source by select, one edge back
  assign ref_exp = (ref_q == 2'h1) ? cyc_q[2] : (ref_q == 2'h2) ? cyc_q[3] : cyc_q[1];
  // Memory drives the byte lines only while it is fetched from
  assign pins = autoboot_busy_o ? {4'h0, mem_b} : {11'h0, sel_s};
  bsc_boot_strap_clock_select bsc_boot_strap_clock_select_i (.clk_i, .nrst_i,
    .boot_source_strap_i(boot_s), .read_strobe_i(rd_s), .write_strobe_i(wr_s),
    .pll_bypass_select_i(byp_s), .mp_pins_i(pins), .boot_length_i(16'h5),
    .host_load_done_i(ld), .app_general_pins_i(app_gen), .app_pins_out_i(~par_oe),
    .app_pins_oe_i(par_oe), .msg_pending_i(msg), .ref_select_i(ref_sel),
    .pll_clock_i(cyc[0]), .bit_clock_one_i(cyc[2]), .bit_clock_two_i(cyc[3]),
    .ref_clock_input_i(cyc[1]), .par_pins_out_i(~par_oe), .par_pins_oe_i(par_oe),
    .timebase_clear_i(1'b0), .mp_pins_o, .mp_pins_oe_o, .boot_pin_o, .boot_pin_oe_o,
    .host_mode_o, .pin_role_o, .waiting_host_o, .autoboot_busy_o, .boot_addr_o,
    .boot_rd_o, .boot_byte_o, .boot_byte_valid_o, .app_running_o, .pll_bypassed_o,
    .reduced_features_o, .pll_ref_sel_o, .pll_ref_clock_o, .dsp_clock_o,
    .audio_timing_tick_o, .av_sync_timebase_o);
  bsc_far_model bsc_far_model_i (.clk_i, .nrst_i, .boot_addr_i(boot_addr_o),
    .waiting_host_i(waiting_host_o), .host_delay_i(hdly), .mem_byte_o(mem_b),
    .load_done_o(ld));
  initial
    forever #4 clk_i = ~clk_i;
  // Sampled clock levels, each at its own rate
  always @(posedge clk_i)
    cyc <= #1 cyc + 8'h1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // Straps are set before reset and held well past capture
  task automatic boot(input logic [4:0] st);
    {boot_s, rd_s, wr_s, sel_s, byp_s} = st;
    nrst_i = 1'b0;
    tick(16);
    rd_cnt = 0;
    nxt = 16'h0;
    nbx = 16'h0;
    nrst_i = 1'b1;
    tick(1);
    check(mp_pins_oe_o, 12'h0);
    tick(11);
  endtask : boot
  task automatic wait_run();
    int n;
    n = 0;
    while (app_running_o !== 1'b1 && n < 500)
    begin
      tick(1);
      n++;
    end
    if (app_running_o !== 1'b1)
    begin
      error_cnt++;
      summarize();
    end
  endtask : wait_run
  // Fetch addresses ascend from zero, each byte pairs with its address
  always @(posedge clk_i)
  begin
    if (boot_rd_o === 1'b1)
    begin
      check(boot_addr_o, nxt);
      check({mp_pins_oe_o, mp_pins_o}, {12'hf00, boot_addr_o[3:0], 8'h00});
      nxt <= nxt + 16'h1;
      rd_cnt <= rd_cnt + 1;
    end
    if (boot_byte_valid_o === 1'b1)
    begin
      check(boot_byte_o, nbx[7:0] ^ 8'h5a);
      nbx <= nbx + 16'h1;
    end
  end
  // Clock paths in run, against the clock levels and select of the edge before
  always @(posedge clk_i)
  begin
    if (app_running_o === 1'b1)
    begin
      check(dsp_clock_o, byp_s ? cyc_q[1] : cyc_q[0]);
      check(pll_ref_sel_o, ref_q);
      check(pll_ref_clock_o, ref_exp);
    end
    cyc_q <= cyc;
    ref_q <= ref_sel;
  end
  initial
  begin
    // SPI straps, autoboot, PLL clock
    boot(5'b01000);
    check(host_mode_o, bsc_pkg::BSC_HOST_SPI);
    check(autoboot_busy_o, 1'b1);
    wait_run();
    check(rd_cnt, 5);
    check(nbx, 16'h5);
    check(pin_role_o, bsc_pkg::BSC_PINS_EXT_MEM);
    check(pll_bypassed_o, 1'b0);
    msg = 1'b1;
    par_oe = 12'h3c1;
    app_gen = 1'b1;
    tick(3);
    check(boot_pin_oe_o, 1'b1);
    check(pin_role_o, bsc_pkg::BSC_PINS_GENERAL);
    check(mp_pins_oe_o, 12'h3c1);
    {rd_s, wr_s} = 2'b01;
    tick(10);
    check(host_mode_o, bsc_pkg::BSC_HOST_SPI);
    msg = 1'b0;
    app_gen = 1'b0;
    // I2C straps, slow host download, PLL bypassed
    hdly = 8'h20;
    boot(5'b10101);
    check(host_mode_o, bsc_pkg::BSC_HOST_I2C);
    check(waiting_host_o, 1'b1);
    check(reduced_features_o, 1'b1);
    wait_run();
    check(rd_cnt, 0);
    // Every select value, timebase advancing once per divider period
    for (int i = 0; i < 4; i++)
    begin
      ref_sel = 2'(i);
      tb0 = av_sync_timebase_o;
      tick(40);
      check(av_sync_timebase_o - tb0, 33'(40 / bsc_pkg::TIMEBASE_DIV));
    end
    // Both parallel variants, prompt host
    hdly = 8'h0;
    par_oe = 12'ha5c;
    for (int s = 0; s < 2; s++)
    begin
      boot({3'b111, s[0], 1'b0});
      check(host_mode_o, s[0] ? 3'h3 : 3'h4);
      check(pin_role_o, bsc_pkg::BSC_PINS_PARALLEL);
      check(mp_pins_oe_o, 12'ha5c);
      wait_run();
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
